//--- core/tp_pkg.sv
// tp_pkg: constants shared by the pulse timer block.
// assumes a 32-bit AXI4-Lite register bus and an 8-bit counter.
package tp_pkg;

  // register byte offsets
  localparam logic [7:0] MODE_OFS   = 8'h00;
  localparam logic [7:0] COUNT_OFS  = 8'h04;
  localparam logic [7:0] RELOAD_OFS = 8'h08;
  localparam logic [7:0] DUTY_OFS   = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // timer_mode_reg field positions
  localparam int RUN_BIT    = 0;
  localparam int WAVE_BIT   = 1;
  localparam int SINGLE_BIT = 2;
  localparam int EXT_BIT    = 3;
  localparam int RATE_LO    = 4;
  localparam int IEN_BIT    = 7;

  // status register field positions
  localparam int FLAG_BIT  = 0;
  localparam int ON_BIT    = 1;
  localparam int ARMED_BIT = 2;

  // counter values and reset values
  localparam logic [7:0] CNT_MAX   = 8'hff;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] RATE_RESET = 3'h0;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // true when a byte address hits a register
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == MODE_OFS) || (a == COUNT_OFS) || (a == RELOAD_OFS)
            || (a == DUTY_OFS) || (a == STATUS_OFS);
  endfunction : addr_hit

endpackage : tp_pkg

//--- core/tp_tick_gen.sv
// tp_tick_gen: one-cycle tick enable for the timer counter.
// assumes ext_in is already synchronous to core_clk.
`timescale 1ns/1ps
module tp_tick_gen (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // selection
  input  wire logic       run,
  input  wire logic       ext_sel,
  input  wire logic [2:0] rate,
  input  wire logic       ext_in,
  // tick enable
  output logic            tick
);
  import tp_pkg::*;

  typedef struct packed {
    logic [7:0] pre;   // prescaler count
    logic       ext_q; // last sample of event input
  } tp_tick_type;

  tp_tick_type st;
  tp_tick_type next_st;
  logic [7:0]  mask;   // low bits that must be all ones

  // prescaler counts only while running off the internal clock
  always_comb begin
    next_st = st;
    mask = 8'(({1'b0, 8'hff} << rate) ^ 9'h1ff);
    next_st.ext_q = ext_in;
    if (run && !ext_sel) begin
      next_st.pre = st.pre + 8'h01;
    end else begin
      next_st.pre = REG_RESET;
    end
    if (ext_sel) begin
      tick = ext_in && !st.ext_q;
    end else begin
      tick = run && ((st.pre & mask) == mask);
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // event mode ignores anything but a rising edge of the pin
  ext_edge_only_a: assert property (ext_sel && !(ext_in && !st.ext_q) |-> !tick)
    else $error("tick without event edge");

endmodule : tp_tick_gen

//--- core/tp_axil_slave.sv
// tp_axil_slave: AXI4-Lite handshakes, one write and one read at a time.
// assumes the register file answers rd_data in the cycle araddr is taken.
`timescale 1ns/1ps
module tp_axil_slave (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address and data
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // register file side
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic [31:0] rd_data
);
  import tp_pkg::*;

  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tp_axil_type;

  tp_axil_type st;
  tp_axil_type next_st;

  // address and data are taken in either order, response after both
  always_comb begin
    next_st = st;
    wr_en = st.aw_got && st.w_got && !st.bvalid;
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.data = s_axi_wdata;
      next_st.strb = s_axi_wstrb;
    end
    if (wr_en) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = addr_hit(st.addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // ready flops stay low until the response is gone
    next_st.awready = !next_st.aw_got && !next_st.bvalid && !wr_en;
    next_st.wready = !next_st.w_got && !next_st.bvalid && !wr_en;
    // read: unmapped reads give zero and an error code
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_data;
      next_st.rresp = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wr_addr = st.addr;
  assign wr_data = st.data;
  assign wr_strb = st.strb;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

endmodule : tp_axil_slave

//--- core/tp_pulse_timer.sv
// tp_pulse_timer: 8-bit auto-reload timer with pwm and single pulse.
// assumes gpio port drives gpio_out/gpio_oe_n and ext_event_in is
// synchronous to core_clk; the pin mux result leaves on pin_out.
//
// Notes on behaviour
// - reload value sets pwm resolution
// - counter equal to duty drives output low
// - duty not above reload keeps output low
// - overflow sets flag; irq only when enabled
// - wave enable hands pin to pwm
// - clearing wave enable restores gpio pin
// - single select plus wave gives one pulse
// - single pulse waits for tick synchronisation
// - pulse end clears wave enable itself
// - single pulse overflow still sets flag
// - external select counts event pin edges
// - cycle starts high, ends on overflow
// - reload on enable and overflow; changes next
`timescale 1ns/1ps
module tp_pulse_timer (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // event counter input
  input  wire logic        ext_event_in,
  // gpio side of the shared pin
  input  wire logic        gpio_out,
  input  wire logic        gpio_oe_n,
  // shared pin
  output logic             pin_out,
  output logic             pin_oe_n,
  // overflow interrupt request
  output logic             irq_req
);
  import tp_pkg::*;

  // all timer state in one word
  typedef struct packed {
    logic       run;       // timer_run_enable
    logic       wave;      // wave_output_enable
    logic       single;    // single_pulse_select
    logic       ext_sel;   // external_clock_select
    logic [2:0] rate;      // prescaler exponent
    logic       ien;       // overflow_irq_enable
    logic [7:0] count;     // tick_counter
    logic [7:0] reload;    // cycle_reload_value
    logic [7:0] duty;      // duty_compare_value
    logic [7:0] reload_sh; // reload in force this cycle
    logic [7:0] duty_sh;   // duty in force this cycle
    logic       flag;      // overflow_flag
    logic       armed;     // single pulse synchronised
    logic       run_q;     // run one cycle ago
    logic       pin_out;
    logic       pin_oe_n;
    logic       irq;
  } tp_state_type;

  tp_state_type st;
  tp_state_type next_st;

  // bus side strobes
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [31:0] rd_data;

  // timer side
  logic       tick;    // one-cycle count enable
  logic       tick_ok; // tick while running
  logic       ovf;     // counter passes 0xff
  logic       pwm_on;  // pin carries the waveform
  logic       level;   // waveform level now
  logic       wr_lane; // low byte lane written
  logic [7:0] mode_rd; // mode register image

  // bus slave
  tp_axil_slave u_bus (
    .core_clk      (core_clk),
    .srst          (srst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .rd_data       (rd_data)
  );

  // timer clock: prescaled core clock or event pin edges
  tp_tick_gen u_tick (
    .core_clk (core_clk),
    .srst     (srst),
    .run      (st.run),
    .ext_sel  (st.ext_sel),
    .rate     (st.rate),
    .ext_in   (ext_event_in),
    .tick     (tick)
  );

  // register read image
  always_comb begin
    mode_rd = {st.ien, st.rate, st.ext_sel, st.single, st.wave, st.run};
    rd_data = 32'h0000_0000;
    unique case (s_axi_araddr)
      MODE_OFS:   rd_data[7:0] = mode_rd;
      COUNT_OFS:  rd_data[7:0] = st.count;
      RELOAD_OFS: rd_data[7:0] = st.reload;
      DUTY_OFS:   rd_data[7:0] = st.duty;
      STATUS_OFS: begin
        rd_data[FLAG_BIT] = st.flag;
        rd_data[ON_BIT] = pwm_on;
        rd_data[ARMED_BIT] = st.armed;
      end
      default:    rd_data = 32'h0000_0000; // unmapped reads zero
    endcase
  end

  // whole timer step: hardware events first, then software writes,
  // then the overflow flag so a set beats a clear in the same cycle
  always_comb begin
    next_st = st;
    tick_ok = tick && st.run;
    ovf = tick_ok && (st.count == CNT_MAX);
    wr_lane = wr_en && wr_strb[0];
    // single pulse needs the pin only once the timer clock is in step
    pwm_on = st.run && st.wave && (!st.single || st.armed);
    level = st.count < st.duty_sh;
    next_st.run_q = st.run;

    // counting and auto-reload
    if (tick_ok) begin
      if (ovf) begin
        // cycle length 256 - reload gives the resolution
        next_st.count = st.reload;
        next_st.reload_sh = st.reload;
        next_st.duty_sh = st.duty;
      end else begin
        next_st.count = st.count + 8'h01;
      end
    end

    // stopped: shadows follow the registers, so the first cycle after
    // enable already compares against the new duty and reload
    if (!st.run) begin
      next_st.reload_sh = st.reload;
      next_st.duty_sh = st.duty;
    end

    // a fresh enable restarts the cycle from reload
    if (st.run && !st.run_q) begin
      next_st.count = st.reload;
      next_st.reload_sh = st.reload;
      next_st.duty_sh = st.duty;
    end

    // single pulse: arm on the first tick after wave enable
    if (st.single && st.wave && tick_ok && !st.armed) begin
      next_st.armed = 1'b1;
      next_st.count = st.reload;
      next_st.reload_sh = st.reload;
      next_st.duty_sh = st.duty;
    end
    if (!st.wave || !st.single || !st.run) begin
      next_st.armed = 1'b0;
    end

    // single pulse done: hand the pin back, no repeat
    if (st.single && st.armed && ovf) begin
      next_st.wave = 1'b0;
      next_st.armed = 1'b0;
    end

    // software writes; a wave set here beats the self clear
    if (wr_lane) begin
      unique case (wr_addr)
        MODE_OFS: begin
          next_st.run = wr_data[RUN_BIT];
          next_st.wave = wr_data[WAVE_BIT];
          next_st.single = wr_data[SINGLE_BIT];
          next_st.ext_sel = wr_data[EXT_BIT];
          next_st.rate = wr_data[RATE_LO +: 3];
          next_st.ien = wr_data[IEN_BIT];
        end
        COUNT_OFS:  next_st.count = wr_data[7:0];
        RELOAD_OFS: next_st.reload = wr_data[7:0];
        DUTY_OFS:   next_st.duty = wr_data[7:0];
        STATUS_OFS: begin
          // write one to clear
          if (wr_data[FLAG_BIT]) begin
            next_st.flag = 1'b0;
          end
        end
        default: begin
          // unmapped write is dropped, bus answers an error
        end
      endcase
    end

    // overflow flag in every mode
    if (ovf) begin
      next_st.flag = 1'b1;
    end

    // pin mux, registered; gpio values pass untouched when off
    if (pwm_on) begin
      next_st.pin_out = level;
      next_st.pin_oe_n = 1'b0;
    end else begin
      next_st.pin_out = gpio_out;
      next_st.pin_oe_n = gpio_oe_n;
    end

    next_st.irq = next_st.flag && next_st.ien;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_out = st.pin_out;
  assign pin_oe_n = st.pin_oe_n;
  assign irq_req = st.irq;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // overflow step of the counter outside single pulse mode
  sequence ovf_s;
    tick && st.run && (st.count == CNT_MAX) && !st.single;
  endsequence

  // continuous pwm stays on with a high-capable duty
  sequence stay_on_s;
    pwm_on && (st.duty_sh > st.reload_sh) && !wr_en;
  endsequence

  ovf_sets_flag_a: assert property (tick && st.run && st.count == CNT_MAX |=> st.flag)
    else $error("overflow did not set flag");

  irq_gate_a: assert property (st.flag && st.ien |-> irq_req)
    else $error("irq missing while enabled");

  irq_masked_a: assert property (!st.ien |-> !irq_req)
    else $error("irq raised while disabled");

  ovf_reload_a: assert property (ovf_s ##0 !wr_en |=> st.count == $past(st.reload))
    else $error("counter not reloaded on overflow");

  count_step_a: assert property (
    tick && st.run && st.run_q && st.count != CNT_MAX && !wr_en && !(st.single && st.wave)
    |=> st.count == $past(st.count) + 8'h01)
    else $error("counter did not step");

  count_hold_a: assert property (!st.run && !st.run_q && !wr_en |=> $stable(st.count))
    else $error("counter moved while stopped");

  low_at_duty_a: assert property (pwm_on && st.count >= st.duty_sh |=> !pin_out)
    else $error("pwm high past duty");

  cycle_high_a: assert property (ovf_s ##0 stay_on_s ##1 stay_on_s |=> pin_out)
    else $error("pwm cycle did not start high");

  gpio_back_a: assert property (!st.wave |=> pin_out == $past(gpio_out)
                                && pin_oe_n == $past(gpio_oe_n))
    else $error("pin not returned to gpio");

  pwm_drive_a: assert property (st.run && st.wave && !st.single |=> !pin_oe_n)
    else $error("pin not driven by pwm");

  sync_wait_a: assert property (st.single && !st.armed && !tick |-> !pwm_on)
    else $error("single pulse before sync");

  // arming happens on the timer tick and restarts the count from reload
  arm_on_tick_a: assert property (
    st.single && st.wave && st.run && !st.armed && tick && !wr_en
    |=> st.armed && st.count == $past(st.reload))
    else $error("single pulse not armed on tick");

  // while stopped the shadow duty tracks the written duty
  shadow_idle_a: assert property (!st.run |=> st.duty_sh == $past(st.duty))
    else $error("duty shadow stale while stopped");

  pulse_end_a: assert property (
    st.single && st.armed && tick && st.count == CNT_MAX && !wr_en
    |=> !st.wave ##1 pin_oe_n == $past(gpio_oe_n))
    else $error("single pulse did not end");

endmodule : tp_pulse_timer

//--- testbench/tp_pin_monitor.sv
// tp_pin_monitor: external receiver of the waveform on the shared pin.
// assumes pin_out is stable at each rising edge of core_clk.
`timescale 1ns/1ps
module tp_pin_monitor (
  // clock and control
  input  wire logic core_clk,
  input  wire logic clr,
  // shared pin
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // measured figures
  output int        n_rise,
  output int        hi_len,
  output int        lo_len
);
  logic prev;     // pin level one cycle ago
  int   run_len;  // cycles spent at the current level

  // count rises and level lengths, only while someone drives the pin
  always @(posedge core_clk) begin
    prev <= pin_out;
    if (clr) begin
      n_rise  <= 0;
      hi_len  <= 0;
      lo_len  <= 0;
      run_len <= 0;
    end else if (!pin_oe_n) begin
      run_len <= run_len + 1;
      // level change: the old level lasted run_len cycles
      if (pin_out !== prev) begin
        run_len <= 1;
        if (pin_out) begin
          n_rise <= n_rise + 1;
          lo_len <= run_len;
        end else begin
          hi_len <= run_len;
        end
      end
    end
  end
endmodule : tp_pin_monitor

//--- testbench/tb_top.sv
// tb_top: self-checking bench for the pulse timer over axi4-lite.
// assumes one write and one read in flight; rate 0 gives a tick per cycle.
`timescale 1ns/1ps
module tb_top;
  import tp_pkg::*;
  // bench-driven inputs
  logic        core_clk = 0, srst = 1, clr = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 0;
  logic        ext_event_in = 0, gpio_out = 0, gpio_oe_n = 0;
  // design outputs
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        pin_out, pin_oe_n, irq_req;
  // monitor figures and bookkeeping
  int          n_rise, hi_len, lo_len, n_errors = 0, checked = 0;
  logic [31:0] rd;
  logic [1:0]  rs;
  // mode and status bit masks
  localparam logic [31:0] M_RUN = 32'h0000_0001 << RUN_BIT;
  localparam logic [31:0] M_WAV = 32'h0000_0001 << WAVE_BIT;
  localparam logic [31:0] M_SGL = 32'h0000_0001 << SINGLE_BIT;
  localparam logic [31:0] M_EXT = 32'h0000_0001 << EXT_BIT;
  localparam logic [31:0] M_IEN = 32'h0000_0001 << IEN_BIT;
  localparam logic [31:0] M_RT1 = 32'h0000_0001 << RATE_LO;
  localparam logic [31:0] FLAG  = 32'h0000_0001 << FLAG_BIT;

  always #2 core_clk = ~core_clk;

  tp_pulse_timer tp_pulse_timer_inst (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_event_in, .gpio_out,
    .gpio_oe_n, .pin_out, .pin_oe_n, .irq_req);
  tp_pin_monitor tp_pin_monitor_inst (.core_clk, .clr, .pin_out, .pin_oe_n, .n_rise,
    .hi_len, .lo_len);

  task automatic stop_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic fail(input string msg);
    n_errors++;
    $display("FAIL %0t %s", $time, msg);
  endtask : fail

  // compare a design value, four-state exact
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) fail(msg);
  endtask : chk32

  // compare a measured figure of the monitor
  task automatic chk_int(input int got, input int exp, input string msg);
    checked++;
    if (got != exp) fail(msg);
  endtask : chk_int

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // bounded wait guard shared by both bus tasks
  task automatic guard(inout int n);
    n++;
    if (n > 200) begin
      fail("bus handshake timeout");
      stop_test();
    end
  endtask : guard

  // one write: address and data offered together, bready held until bvalid
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    bit done = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 0;
        done = 1;
      end
      guard(n);
    end
  endtask : axi_wr

  // one read: rready held until rvalid, data taken at that edge
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    bit done = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        done = 1;
      end
      guard(n);
    end
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rs);
    chk32(32'(rs), 32'(RESP_OKAY), "write response");
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    axi_rd(a, rd, rs);
    chk32(rd, exp, msg);
  endtask : rd_chk

  task automatic clear_mon();
    clr <= 1;
    cyc(1);
    clr <= 0;
  endtask : clear_mon

  // software setup in the documented order
  task automatic setup(input logic [7:0] rl, input logic [7:0] du, input logic [31:0] m);
    wr(MODE_OFS, 32'h0000_0000);
    wr(COUNT_OFS, {24'h0, rl});
    wr(RELOAD_OFS, {24'h0, rl});
    wr(DUTY_OFS, {24'h0, du});
    wr(MODE_OFS, m & ~M_RUN);
    wr(MODE_OFS, m);
  endtask : setup

  // reset values, unmapped place refused
  task automatic t_reset();
    logic [7:0] ofs[5] = '{MODE_OFS, COUNT_OFS, RELOAD_OFS, DUTY_OFS, STATUS_OFS};
    foreach (ofs[i]) rd_chk(ofs[i], 32'h0000_0000, "reset value");
    axi_rd(8'h14, rd, rs);
    chk32(32'(rs), 32'(RESP_SLVERR), "unmapped read");
    axi_wr(8'h14, 32'h0000_00ff, rs);
    chk32(32'(rs), 32'(RESP_SLVERR), "unmapped write");
  endtask : t_reset

  // continuous pwm at three resolutions, then a duty change in flight
  task automatic t_pwm();
    logic [7:0] rl[3] = '{8'h00, 8'h80, 8'hf0};
    logic [7:0] du[3] = '{8'h80, 8'hc0, 8'hf8};
    for (int i = 0; i < 3; i++) begin
      setup(rl[i], du[i], M_WAV | M_RUN);
      clear_mon();
      cyc(2 * (256 - int'(rl[i])) + 20);
      chk_int(hi_len, int'(du[i]) - int'(rl[i]), "high width");
      chk_int(lo_len, 256 - int'(du[i]), "low width");
      chk32(32'(pin_oe_n), 32'h0, "pin not driven by pwm");
      rd_chk(STATUS_OFS, FLAG | 32'h2, "flag or pin not pwm");
    end
    wr(DUTY_OFS, 32'h0000_00fc);
    cyc(40);
    chk_int(hi_len, 12, "new duty high");
    chk_int(lo_len, 4, "new duty low");
  endtask : t_pwm

  // prescaler rate 1: every count lasts two core cycles
  task automatic t_rate();
    setup(8'hf0, 8'hf8, M_WAV | M_RUN | M_RT1);
    clear_mon();
    cyc(84);
    chk_int(hi_len, 16, "rate high width");
    chk_int(lo_len, 16, "rate low width");
  endtask : t_rate

  // duty not above reload keeps the pin low
  task automatic t_low();
    setup(8'hf0, 8'hf0, M_WAV | M_RUN);
    clear_mon();
    cyc(60);
    chk_int(n_rise, 0, "equal duty pulsed");
    wr(DUTY_OFS, 32'h0000_00e0);
    cyc(40);
    chk_int(n_rise, 0, "small duty pulsed");
    chk32({31'h0, pin_out}, 32'h0, "pin not low");
  endtask : t_low

  // wave off hands the pin back, timer keeps counting
  task automatic t_gpio();
    logic [31:0] c0;
    gpio_out <= 1;
    gpio_oe_n <= 1;
    wr(MODE_OFS, M_RUN);
    cyc(3);
    chk32({pin_oe_n, pin_out}, 32'h3, "gpio not restored");
    axi_rd(COUNT_OFS, c0, rs);
    axi_rd(COUNT_OFS, rd, rs);
    chk_int(int'(c0 != rd), 1, "timer stopped");
    gpio_out <= 0;
    gpio_oe_n <= 0;
  endtask : t_gpio

  // overflow flag always, request only when enabled
  task automatic t_flag();
    setup(8'hf0, 8'hf8, M_WAV);
    wr(STATUS_OFS, FLAG);
    wr(MODE_OFS, M_WAV | M_RUN);
    cyc(40);
    chk32({31'h0, irq_req}, 32'h0, "request while disabled");
    rd_chk(STATUS_OFS, FLAG | 32'h2, "flag not set");
    wr(MODE_OFS, M_WAV | M_RUN | M_IEN);
    cyc(2);
    chk32({31'h0, irq_req}, 32'h1, "no request");
    wr(MODE_OFS, M_IEN);
    wr(STATUS_OFS, FLAG);
    cyc(2);
    chk32({31'h0, irq_req}, 32'h0, "request after clear");
  endtask : t_flag

  // one pulse, self clear, re-armed only by software
  task automatic t_single();
    clear_mon();
    setup(8'hf0, 8'hf8, M_WAV | M_SGL | M_RUN);
    cyc(80);
    chk_int(n_rise, 1, "pulse count");
    chk_int(hi_len, 8, "pulse width");
    rd_chk(MODE_OFS, M_SGL | M_RUN, "wave not cleared");
    rd_chk(STATUS_OFS, FLAG, "flag or pin state");
    cyc(60);
    chk_int(n_rise, 1, "pulse repeated");
    wr(MODE_OFS, M_WAV | M_SGL | M_RUN);
    cyc(60);
    chk_int(n_rise, 2, "second pulse");
  endtask : t_single

  // event counting on the external pin, holding while stopped
  task automatic ext_edges(input int n);
    repeat (n) begin
      ext_event_in <= 1;
      cyc(2);
      ext_event_in <= 0;
      cyc(2);
    end
  endtask : ext_edges

  task automatic t_ext();
    setup(8'h10, 8'h00, M_EXT | M_RUN);
    cyc(4);
    ext_edges(5);
    wr(MODE_OFS, M_EXT);
    rd_chk(COUNT_OFS, 32'h0000_0015, "event count");
    ext_edges(3);
    rd_chk(COUNT_OFS, 32'h0000_0015, "count moved while stopped");
  endtask : t_ext

  // main sequence
  initial begin
    cyc(16);
    srst <= 0;
    cyc(2);
    t_reset();
    t_pwm();
    t_rate();
    t_low();
    t_gpio();
    t_flag();
    t_single();
    t_ext();
    stop_test();
  end
endmodule : tb_top
